// ==== include/sfc_pkg.sv ====
// Purpose: Constants and types of the serial flash command front end.
// Assumes: SPI mode 0 or 3 framing, byte-wide opcodes.
// Notes:   Status byte layout and opcode map live here only.
package sfc_pkg;
	localparam logic [7:0] OP_STATUS_RD    = 8'h05;
	localparam logic [7:0] OP_STATUS_WR    = 8'h01;
	localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OP_WRITE_LOCK   = 8'h04;
	localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
	localparam logic [7:0] OP_SMALL_ERASE  = 8'h20;
	localparam logic [7:0] OP_HALF_ERASE   = 8'h52;
	localparam logic [7:0] OP_LARGE_ERASE  = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OP_READ         = 8'h03;
	localparam logic [7:0] OP_FAST_READ    = 8'h0b;
	localparam logic [7:0] OP_DUAL_READ    = 8'h3b;
	localparam logic [7:0] OP_UNIQUE_ID    = 8'h4b;
	localparam logic [7:0] OP_ENTER_SLEEP  = 8'hb9;
	localparam logic [7:0] OP_WAKE_ID      = 8'hab;
	localparam logic [7:0] OP_MAKER_ID     = 8'h90;
	localparam logic [7:0] OP_JEDEC_ID     = 8'h9f;
	localparam logic [2:0] ADDR_BYTES      = 3'h3;
	localparam logic [2:0] ADDR_DUMMY      = 3'h4;
	localparam logic [2:0] KIND_STATUS     = 3'h0;
	localparam logic [2:0] KIND_PAGE       = 3'h1;
	localparam logic [2:0] KIND_SMALL      = 3'h2;
	localparam logic [2:0] KIND_HALF       = 3'h3;
	localparam logic [2:0] KIND_LARGE      = 3'h4;
	localparam logic [2:0] KIND_CHIP       = 3'h5;
	localparam int         SR_LOCK_BIT     = 7;
	localparam int         SR_PROT_HI      = 4;
	localparam int         SR_PROT_LO      = 2;
	localparam int         SR_LATCH_BIT    = 1;
	localparam int         SR_BUSY_BIT     = 0;

	typedef enum logic [1:0] {PH_OPC, PH_ARG, PH_OUT, PH_SKIP} sfc_phase_t;

	typedef struct packed {
		logic [1:0]  csS;
		logic [1:0]  ckS;
		logic [1:0]  diS;
		logic        csPrev;
		logic        ckPrev;
		sfc_phase_t  phase;
		logic [7:0]  opc;
		logic [2:0]  bitCnt;
		logic [7:0]  shIn;
		logic [2:0]  byteCnt;
		logic [23:0] addr;
		logic [7:0]  shOut;
		logic [2:0]  outLeft;
		logic [3:0]  outIdx;
		logic [7:0]  srData;
		logic        overrun;
		logic        writeLatch;
		logic        busy;
		logic        sleep;
		logic        statusLock;
		logic [2:0]  prot;
		logic        cmdStart;
		logic [2:0]  cmdKind;
		logic [23:0] cmdAddr;
		logic        flush;
		logic        push;
		logic [7:0]  pushData;
		logic        soOut;
		logic        soOeN;
		logic        l0Out;
		logic        l0OeN;
		logic        active;
	} sfc_state_t;

	localparam sfc_state_t ST_RESET = '{csS: 2'h3, csPrev: 1'b1, phase: PH_OPC,
		soOeN: 1'b1, l0OeN: 1'b1, default: '0};

	function automatic logic [2:0] argLen(input logic [7:0] op);
		case (op)
			OP_READ, OP_WAKE_ID, OP_MAKER_ID:         argLen = ADDR_BYTES;
			OP_FAST_READ, OP_DUAL_READ, OP_UNIQUE_ID: argLen = ADDR_DUMMY;
			default:                                  argLen = 3'h0;
		endcase
	endfunction

	function automatic logic hasOut(input logic [7:0] op);
		hasOut = op inside {OP_STATUS_RD, OP_READ, OP_FAST_READ, OP_DUAL_READ,
			OP_UNIQUE_ID, OP_WAKE_ID, OP_MAKER_ID, OP_JEDEC_ID};
	endfunction

	function automatic logic isKnown(input logic [7:0] op);
		isKnown = hasOut(op) || (op inside {OP_STATUS_WR, OP_WRITE_UNLOCK, OP_WRITE_LOCK,
			OP_PAGE_WRITE, OP_SMALL_ERASE, OP_HALF_ERASE, OP_LARGE_ERASE,
			OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_ENTER_SLEEP});
	endfunction
endpackage

// ==== hdl/sfc_front_end.sv ====
// Purpose: SPI command front end of a small serial NOR flash.
// Assumes: clk far faster than sclk; engine and array on clk.
// Notes:   Pins pass a two-stage synchroniser before use.
`timescale 1ns/1ps

module sfc_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         flush,
	// Fill side
	input  wire logic         inValid,
	input  wire logic [W-1:0] inData,
	output logic              inReady,
	// Drain side
	output logic              outValid,
	output logic [W-1:0]      outData,
	input  wire logic         outReady
);
	localparam int PW = $clog2(D);
	localparam int CW = $clog2(D + 1);
	localparam logic [CW-1:0] FULL = CW'(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [PW-1:0]       wrPtr;
		logic [PW-1:0]       rdPtr;
		logic [CW-1:0]       count;
	} sfc_fifo_st_t;

	sfc_fifo_st_t st_r;
	sfc_fifo_st_t st_nxt;
	logic         doWr;
	logic         doRd;

	assign inReady  = st_r.count != FULL;
	assign outValid = st_r.count != '0;
	assign outData  = st_r.mem[st_r.rdPtr];

	always_comb begin
		st_nxt = st_r;
		doWr = inValid && inReady;
		doRd = outValid && outReady;
		for (int i = 0; i < D; i++) begin
			if (doWr && st_r.wrPtr == PW'(i)) begin
				st_nxt.mem[i] = inData;
			end
		end
		if (doWr) begin
			st_nxt.wrPtr = st_r.wrPtr + 1'b1;
		end
		if (doRd) begin
			st_nxt.rdPtr = st_r.rdPtr + 1'b1;
		end
		st_nxt.count = st_r.count + CW'(doWr) - CW'(doRd);
		if (flush) begin
			st_nxt.wrPtr = '0;
			st_nxt.rdPtr = '0;
			st_nxt.count = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	fifoFull_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_r.count == FULL |-> !inReady && outValid) else $error("fifo full flags wrong");
endmodule

module sfc_front_end #(
	parameter logic [7:0] MAKER_CODE  = 8'h3a,  // Arbitrary value
	parameter logic [7:0] DEVICE_CODE = 8'h4c,  // Arbitrary value
	parameter logic [7:0] MEM_TYPE    = 8'h2d,  // Arbitrary value
	parameter logic [7:0] CAPACITY    = 8'h07   // Arbitrary value
) (
	// Clock, reset, enable
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	// SPI pins
	input  wire logic          csN,
	input  wire logic          sclk,
	input  wire logic          serialIn,
	output logic               dualLane0Out,
	output logic               dualLane0OeN,
	output logic               serialOut,
	output logic               serialOutOeN,
	// Array and identifier read
	output logic [23:0]        rdAddr,
	input  wire logic [7:0]    rdData,
	input  wire logic [127:0]  uniqueId,
	// Program and erase engine
	output logic               cmdStart,
	output logic [2:0]         cmdKind,
	output logic [23:0]        cmdAddr,
	input  wire logic          engineDone,
	output logic [7:0]         pgmData,
	output logic               pgmValid,
	input  wire logic          pgmReady,
	// Status view
	output logic               writeLatch,
	output logic               busy,
	output logic               sleepMode,
	output logic               activeMode,
	output logic               statusLock,
	output logic [2:0]         protLevel
);
	sfc_pkg::sfc_state_t st;
	sfc_pkg::sfc_state_t n;
	logic       pgmInReady;
	logic       opcEv;
	logic       endEv;
	logic       loadEv;
	logic       rise;
	logic       fall;
	logic       dual;
	logic       arrayRd;
	logic       accept;
	logic [7:0] byteIn;
	logic [7:0] statusByte;
	logic [7:0] nextByte;

	assign dualLane0Out = st.l0Out;
	assign dualLane0OeN = st.l0OeN;
	assign serialOut    = st.soOut;
	assign serialOutOeN = st.soOeN;
	assign rdAddr       = st.addr;
	assign cmdStart     = st.cmdStart;
	assign cmdKind      = st.cmdKind;
	assign cmdAddr      = st.cmdAddr;
	assign writeLatch   = st.writeLatch;
	assign busy         = st.busy;
	assign sleepMode    = st.sleep;
	assign activeMode   = st.active;
	assign statusLock   = st.statusLock;
	assign protLevel    = st.prot;

	// Program data staging; engine drains at its own pace
	sfc_fifo #(.W(8), .D(8)) dataFifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.flush    (st.flush),
		.inValid  (st.push),
		.inData   (st.pushData),
		.inReady  (pgmInReady),
		.outValid (pgmValid),
		.outData  (pgmData),
		.outReady (pgmReady)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = st;
		n.cmdStart = 1'b0;
		n.flush    = 1'b0;
		n.push     = 1'b0;
		n.csS      = {st.csS[0], csN};
		n.ckS      = {st.ckS[0], sclk};
		n.diS      = {st.diS[0], serialIn};
		n.csPrev   = st.csS[1];
		n.ckPrev   = st.ckS[1];
		n.active   = !st.csS[1] || st.busy;
		byteIn     = {st.shIn[6:0], st.diS[1]};
		dual       = st.opc == sfc_pkg::OP_DUAL_READ;
		arrayRd    = st.opc inside {sfc_pkg::OP_READ, sfc_pkg::OP_FAST_READ, sfc_pkg::OP_DUAL_READ};
		endEv      = st.csS[1] && !st.csPrev;
		rise       = !st.csS[1] && st.ckS[1] && !st.ckPrev;
		fall       = !st.csS[1] && !st.ckS[1] && st.ckPrev;
		opcEv      = 1'b0;
		loadEv     = 1'b0;
		accept     = 1'b0;
		statusByte = 8'h00;
		statusByte[sfc_pkg::SR_LOCK_BIT] = st.statusLock;
		statusByte[sfc_pkg::SR_PROT_HI:sfc_pkg::SR_PROT_LO] = st.prot;
		statusByte[sfc_pkg::SR_LATCH_BIT] = st.writeLatch;
		statusByte[sfc_pkg::SR_BUSY_BIT] = st.busy;
		case (st.opc)
			sfc_pkg::OP_STATUS_RD: nextByte = statusByte;
			sfc_pkg::OP_READ, sfc_pkg::OP_FAST_READ, sfc_pkg::OP_DUAL_READ: nextByte = rdData;
			sfc_pkg::OP_UNIQUE_ID: nextByte = uniqueId[{~st.outIdx, 3'h0} +: 8];
			sfc_pkg::OP_WAKE_ID: nextByte = DEVICE_CODE;
			sfc_pkg::OP_MAKER_ID: nextByte = (st.addr[0] ^ st.outIdx[0]) ? DEVICE_CODE : MAKER_CODE;
			sfc_pkg::OP_JEDEC_ID: begin
				case (st.outIdx)
					4'h0:    nextByte = MAKER_CODE;
					4'h1:    nextByte = MEM_TYPE;
					4'h2:    nextByte = CAPACITY;
					default: nextByte = 8'h00;
				endcase
			end
			default: nextByte = 8'h00;
		endcase

		// Self-timed cycle ends
		if (engineDone && st.busy) begin
			n.busy       = 1'b0;
			n.writeLatch = 1'b0;
		end

		if (st.csS[1]) begin
			// Select high: commit a whole-byte instruction, then idle
			if (endEv && st.phase == sfc_pkg::PH_ARG && st.bitCnt == 3'h0) begin
				unique case (st.opc)
					sfc_pkg::OP_WRITE_UNLOCK: begin
						if (st.byteCnt == 3'h0) n.writeLatch = 1'b1;
					end
					sfc_pkg::OP_WRITE_LOCK: begin
						if (st.byteCnt == 3'h0) n.writeLatch = 1'b0;
					end
					sfc_pkg::OP_ENTER_SLEEP: begin
						if (st.byteCnt == 3'h0) n.sleep = 1'b1;
					end
					sfc_pkg::OP_STATUS_WR: begin
						if (st.byteCnt != 3'h0 && st.writeLatch) begin
							n.statusLock = st.srData[sfc_pkg::SR_LOCK_BIT];
							n.prot = st.srData[sfc_pkg::SR_PROT_HI:sfc_pkg::SR_PROT_LO];
							n.cmdKind = sfc_pkg::KIND_STATUS;
							accept = 1'b1;
						end
					end
					sfc_pkg::OP_PAGE_WRITE: begin
						if (st.byteCnt > sfc_pkg::ADDR_BYTES && st.writeLatch && !st.overrun) begin
							n.cmdKind = sfc_pkg::KIND_PAGE;
							accept = 1'b1;
						end
					end
					sfc_pkg::OP_SMALL_ERASE, sfc_pkg::OP_HALF_ERASE, sfc_pkg::OP_LARGE_ERASE: begin
						if (st.byteCnt == sfc_pkg::ADDR_BYTES && st.writeLatch) begin
							if (st.opc == sfc_pkg::OP_SMALL_ERASE) n.cmdKind = sfc_pkg::KIND_SMALL;
							else if (st.opc == sfc_pkg::OP_HALF_ERASE) n.cmdKind = sfc_pkg::KIND_HALF;
							else n.cmdKind = sfc_pkg::KIND_LARGE;
							accept = 1'b1;
						end
					end
					sfc_pkg::OP_CHIP_ERASE_A, sfc_pkg::OP_CHIP_ERASE_B: begin
						if (st.byteCnt == 3'h0 && st.writeLatch) begin
							n.cmdKind = sfc_pkg::KIND_CHIP;
							accept = 1'b1;
						end
					end
					default: ;
				endcase
			end
			if (accept) begin
				n.cmdStart = 1'b1;
				n.cmdAddr  = st.addr;
				n.busy     = 1'b1;
			end
			// Staged program bytes are dropped unless the page write was taken
			if (endEv && st.opc == sfc_pkg::OP_PAGE_WRITE && !accept) begin
				n.flush = 1'b1;
			end
			n.phase   = sfc_pkg::PH_OPC;
			n.bitCnt  = 3'h0;
			n.byteCnt = 3'h0;
			n.shIn    = 8'h00;
			n.outLeft = 3'h0;
			n.outIdx  = 4'h0;
			n.overrun = 1'b0;
			n.soOeN   = 1'b1;
			n.l0OeN   = 1'b1;
		end else begin
			if (rise) begin
				n.shIn   = byteIn;
				n.bitCnt = st.bitCnt + 3'h1;
				if (st.bitCnt == 3'h7) begin
					unique case (st.phase)
						sfc_pkg::PH_OPC: begin
							opcEv = 1'b1;
							n.opc = byteIn;
							if (!sfc_pkg::isKnown(byteIn)) begin
								n.phase = sfc_pkg::PH_SKIP;
							end else if (st.sleep && byteIn != sfc_pkg::OP_WAKE_ID) begin
								n.phase = sfc_pkg::PH_SKIP;
							end else if (st.busy && byteIn != sfc_pkg::OP_STATUS_RD) begin
								n.phase = sfc_pkg::PH_SKIP;
							end else begin
								n.sleep = 1'b0;
								if (sfc_pkg::hasOut(byteIn) && sfc_pkg::argLen(byteIn) == 3'h0) begin
									n.phase = sfc_pkg::PH_OUT;
								end else begin
									n.phase = sfc_pkg::PH_ARG;
								end
							end
						end
						sfc_pkg::PH_ARG: begin
							if (st.byteCnt < sfc_pkg::ADDR_BYTES) begin
								n.addr = {st.addr[15:0], byteIn};
							end
							if (st.byteCnt != 3'h7) begin
								n.byteCnt = st.byteCnt + 3'h1;
							end
							if (st.opc == sfc_pkg::OP_STATUS_WR && st.byteCnt == 3'h0) begin
								n.srData = byteIn;
							end
							if (st.opc == sfc_pkg::OP_PAGE_WRITE && st.byteCnt >= sfc_pkg::ADDR_BYTES) begin
								// Link cannot stall: a full buffer spoils the page write
								if (pgmInReady) begin
									n.push     = 1'b1;
									n.pushData = byteIn;
								end else begin
									n.overrun = 1'b1;
								end
							end
							if (sfc_pkg::hasOut(st.opc) && st.byteCnt + 3'h1 == sfc_pkg::argLen(st.opc)) begin
								n.phase = sfc_pkg::PH_OUT;
							end
						end
						sfc_pkg::PH_OUT, sfc_pkg::PH_SKIP: ;
					endcase
				end
			end
			if (fall && st.phase == sfc_pkg::PH_OUT) begin
				n.soOeN = 1'b0;
				if (st.outLeft == 3'h0) begin
					loadEv   = 1'b1;
					n.soOut  = nextByte[7];
					n.outIdx = st.outIdx + 4'h1;
					if (arrayRd) begin
						n.addr = st.addr + 24'h1;
					end
					if (dual) begin
						n.l0OeN   = 1'b0;
						n.l0Out   = nextByte[6];
						n.shOut   = {nextByte[5:0], 2'h0};
						n.outLeft = 3'h3;
					end else begin
						n.shOut   = {nextByte[6:0], 1'h0};
						n.outLeft = 3'h7;
					end
				end else begin
					n.soOut   = st.shOut[7];
					n.outLeft = st.outLeft - 3'h1;
					if (dual) begin
						n.l0Out = st.shOut[6];
						n.shOut = {st.shOut[5:0], 2'h0};
					end else begin
						n.shOut = {st.shOut[6:0], 1'h0};
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= sfc_pkg::ST_RESET;
		end else if (ce) begin
			st <= n;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);

	sequence sEndWhole;
		endEv && st.bitCnt == 3'h0 && st.phase == sfc_pkg::PH_ARG;
	endsequence

	sequence sEndBroken;
		endEv && st.bitCnt != 3'h0;
	endsequence

	busyIgnore_a: assert property (
		opcEv && st.busy && byteIn != sfc_pkg::OP_STATUS_RD |=> st.phase == sfc_pkg::PH_SKIP)
		else $error("opcode taken while busy");
	sleepIgnore_a: assert property (
		opcEv && st.sleep && byteIn != sfc_pkg::OP_WAKE_ID |=> st.phase == sfc_pkg::PH_SKIP && st.sleep)
		else $error("opcode taken in sleep");
	wakeClear_a: assert property (
		opcEv && st.sleep && byteIn == sfc_pkg::OP_WAKE_ID && !st.busy |=> !st.sleep)
		else $error("wake opcode did not wake");
	unknownSkip_a: assert property (
		opcEv && !sfc_pkg::isKnown(byteIn) |=> st.phase == sfc_pkg::PH_SKIP ##1 $stable(st.sleep))
		else $error("unknown opcode not ignored");
	sleepEnter_a: assert property (
		sEndWhole ##0 (st.opc == sfc_pkg::OP_ENTER_SLEEP && st.byteCnt == 3'h0) |=> st.sleep)
		else $error("sleep not entered");
	unlockSet_a: assert property (
		sEndWhole ##0 (st.opc == sfc_pkg::OP_WRITE_UNLOCK && st.byteCnt == 3'h0) |=> st.writeLatch)
		else $error("write latch not set");
	lockClear_a: assert property (
		sEndWhole ##0 (st.opc == sfc_pkg::OP_WRITE_LOCK && st.byteCnt == 3'h0) |=> !st.writeLatch)
		else $error("write latch not cleared");
	brokenWrite_a: assert property (
		sEndBroken |=> !st.cmdStart) else $error("partial byte started a cycle");
	doneClear_a: assert property (
		engineDone && st.busy |=> !st.busy && !st.writeLatch) else $error("cycle end left busy or latch");
	startBusy_a: assert property (
		st.cmdStart |-> st.busy && statusByte[sfc_pkg::SR_BUSY_BIT]) else $error("cycle without busy");
	outOff_a: assert property (
		st.csS[1] |=> st.soOeN && st.l0OeN) else $error("output driven while deselected");
	statusOut_a: assert property (
		loadEv && st.opc == sfc_pkg::OP_STATUS_RD |=> !st.soOeN && st.soOut == $past(statusByte[7]))
		else $error("status MSB not driven");
	dualSplit_a: assert property (
		loadEv && dual |=> st.soOut == $past(nextByte[7]) && st.l0Out == $past(nextByte[6]))
		else $error("dual lanes carry wrong bits");
endmodule

// ==== test/sfc_host_model.sv ====
// Purpose: SPI host model that drives the flash front end pins.
// Assumes: Mode 0, sclk idle low between frames, 48 ns period.
// Notes:   Device bits are sampled on the sclk rise; data pin toggles when not in use.
`timescale 1ns/1ps

module sfc_host_model (
	// Bench clock, only to place pin changes just after its edge
	input  wire logic clk,
	// SPI pins
	output logic      csN,
	output logic      sclk,
	output logic      serialIn,
	input  wire logic serialOut,
	input  wire logic dualLane0Out
);
	logic [63:0] rx1;
	logic [63:0] rx0;

	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		serialIn = 1'b0;
	end

	// Sends nTx bits of tx from bit 63 down, wrapping, then nRx read clocks
	task automatic xfer(input int nTx, input logic [63:0] tx, input int nRx);
		// Half period is a whole number of clk periods, so every pin edge stays off the clk edge
		@(posedge clk);
		#1;
		rx1 = '0;
		rx0 = '0;
		csN = 1'b0;
		for (int i = 0; i < nTx + nRx; i++) begin
			serialIn = (i < nTx) ? tx[63 - (i % 64)] : ~serialIn;
			#24 sclk = 1'b1;
			rx1 = {rx1[62:0], serialOut};
			rx0 = {rx0[62:0], dualLane0Out};
			#24 sclk = 1'b0;
		end
		#24 csN = 1'b1;
		serialIn = ~serialIn;
		#48;
	endtask
endmodule

// ==== test/sfc_front_end_tb.sv ====
// Purpose: Self-checking bench of the flash command front end.
// Assumes: Host model drives the pins; bench plays array and engine.
// Notes:   Array byte is the address low byte xor 5a.
`timescale 1ns/1ps

module sfc_front_end_tb;
	localparam logic [7:0]   MK  = 8'h3a; // Arbitrary value
	localparam logic [7:0]   DV  = 8'h4c; // Arbitrary value
	localparam logic [7:0]   MT  = 8'h2d; // Arbitrary value
	localparam logic [7:0]   CP  = 8'h07; // Arbitrary value
	localparam logic [127:0] UID = 128'h0123456789abcdeffedcba9876543210;

	logic        clk = 1'b0;
	logic        rst_n, ce, engineDone, pgmReady;
	logic        csN, sclk, hostSi, siPin, soPin;
	logic        l0Out, l0OeN, so, soOeN, cmdStart, pgmValid;
	logic        writeLatch, busy, sleepMode, activeMode, statusLock;
	logic [2:0]  cmdKind, protLevel;
	logic [23:0] rdAddr, cmdAddr;
	logic [7:0]  rdData, pgmData;
	logic        expLock = 1'b0;
	logic [2:0]  expProt = 3'h0;
	int          errTotal = 0;
	int          checked = 0;
	int          starts = 0;
	int          oeCnt = 0;

	// Shared pin: device wins only while it drives
	assign siPin = l0OeN ? hostSi : l0Out;
	assign soPin = soOeN ? 1'bz : so;

	always #2 clk = ~clk;
	always @(posedge clk) rdData <= #1 rdAddr[7:0] ^ 8'h5a;
	always @(posedge clk) if (cmdStart === 1'b1) starts++;
	always @(posedge clk) if (soOeN === 1'b0) oeCnt++;

	sfc_front_end #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .MEM_TYPE(MT), .CAPACITY(CP)) dut (
		.clk(clk), .rst_n(rst_n), .ce(ce),
		.csN(csN), .sclk(sclk), .serialIn(siPin),
		.dualLane0Out(l0Out), .dualLane0OeN(l0OeN), .serialOut(so), .serialOutOeN(soOeN),
		.rdAddr(rdAddr), .rdData(rdData), .uniqueId(UID),
		.cmdStart(cmdStart), .cmdKind(cmdKind), .cmdAddr(cmdAddr), .engineDone(engineDone),
		.pgmData(pgmData), .pgmValid(pgmValid), .pgmReady(pgmReady),
		.writeLatch(writeLatch), .busy(busy), .sleepMode(sleepMode), .activeMode(activeMode),
		.statusLock(statusLock), .protLevel(protLevel)
	);

	sfc_host_model host (
		.clk(clk), .csN(csN), .sclk(sclk), .serialIn(hostSi), .serialOut(soPin), .dualLane0Out(siPin)
	);

	//--------------------------------------------------------------
	// Helpers
	//--------------------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			errTotal++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic op(input logic [7:0] b);
		host.xfer(8, {b, 56'h0}, 0);
	endtask

	task automatic pulse(ref logic s);
		@(posedge clk);
		#1 s = 1'b1;
		@(posedge clk);
		#1 s = 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic giveVerdict();
		if (errTotal == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	//--------------------------------------------------------------
	// Scenarios
	//--------------------------------------------------------------
	task automatic tLatch();
		chk("wl reset", writeLatch, 0);
		chk("oe reset", {soOeN, l0OeN, busy, sleepMode}, 4'hc);
		op(8'h06);
		chk("wl set", writeLatch, 1);
		host.xfer(8, {8'h05, 56'h0}, 16);
		chk("status", host.rx1[15:0], 16'h0202);
		chk("oe idle", soOeN, 1);
		op(8'h04);
		chk("wl clr", writeLatch, 0);
	endtask

	task automatic tErase();
		logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
		int n0;
		for (int k = 0; k < 5; k++) begin
			op(8'h06);
			n0 = starts;
			host.xfer(k < 3 ? 32 : 8, {ops[k], 24'h012345, 32'h0}, 0);
			chk("start", starts - n0, 1);
			chk("kind", cmdKind, k < 3 ? k + 2 : 5);
			if (k < 3) chk("addr", cmdAddr, 24'h012345);
			chk("busy", {busy, activeMode}, 2'h3);
			op(8'h04);
			chk("ignored", writeLatch, 1);
			host.xfer(8, {8'h05, 56'h0}, 8);
			chk("poll", host.rx1[7:0], {expLock, 2'b00, expProt, 2'b11});
			pulse(engineDone);
			chk("done", {busy, writeLatch, activeMode}, 3'h0);
		end
		op(8'h06);
		n0 = starts;
		host.xfer(31, {8'h20, 56'h0}, 0);
		op(8'h04);
		host.xfer(32, {8'h20, 56'h0}, 0);
		chk("discard", starts - n0, 0);
		chk("no busy", busy, 0);
	endtask

	task automatic tStatusWr(input logic [7:0] v);
		op(8'h06);
		host.xfer(16, {8'h01, v, 48'h0}, 0);
		expLock = v[7];
		expProt = v[4:2];
		chk("lock", {statusLock, protLevel}, {expLock, expProt});
		chk("sw busy", busy, 1);
		pulse(engineDone);
		host.xfer(8, {8'h05, 56'h0}, 16);
		chk("sr", host.rx1[15:0], {2{expLock, 2'b00, expProt, 2'b00}});
	endtask

	task automatic tRead();
		logic [7:0] d;
		host.xfer(32, {8'h03, 24'h000123, 32'h0}, 16);
		chk("read", host.rx1[15:0], {8'h23 ^ 8'h5a, 8'h24 ^ 8'h5a});
		host.xfer(40, {8'h0b, 24'h000140, 32'h0}, 8);
		chk("fast", host.rx1[7:0], 8'h40 ^ 8'h5a);
		host.xfer(40, {8'h3b, 24'h000177, 32'h0}, 4);
		d = 8'h77 ^ 8'h5a;
		chk("lane1", host.rx1[3:0], {d[7], d[5], d[3], d[1]});
		chk("lane0", host.rx0[3:0], {d[6], d[4], d[2], d[0]});
		host.xfer(32, {8'h03, 56'h0}, 3);
		chk("abort oe", {soOeN, l0OeN}, 2'h3);
		op(8'h06);
		chk("after abort", writeLatch, 1);
		op(8'h04);
	endtask

	task automatic tIds();
		host.xfer(8, {8'h9f, 56'h0}, 32);
		chk("jedec", host.rx1[31:0], {MK, MT, CP, 8'h00});
		host.xfer(32, {8'h90, 56'h0}, 16);
		chk("id0", host.rx1[15:0], {MK, DV});
		host.xfer(32, {8'h90, 24'h000001, 32'h0}, 16);
		chk("id1", host.rx1[15:0], {DV, MK});
		host.xfer(32, {8'hab, 56'h0}, 16);
		chk("dev", host.rx1[15:0], {DV, DV});
		host.xfer(40, {8'h4b, 56'h0}, 64);
		chk("uid", host.rx1, UID[127:64]);
	endtask

	task automatic tSleep();
		int n0;
		op(8'hb9);
		chk("sleep", sleepMode, 1);
		n0 = oeCnt;
		op(8'h06);
		host.xfer(8, {8'h05, 56'h0}, 8);
		chk("asleep", {writeLatch, oeCnt - n0}, 0);
		host.xfer(32, {8'hab, 56'h0}, 8);
		chk("wake", {sleepMode, host.rx1[7:0]}, {1'b0, DV});
		op(8'h06);
		n0 = oeCnt;
		host.xfer(8, {8'h77, 56'h0}, 16);
		chk("unknown oe", oeCnt - n0, 0);
		chk("unknown", {writeLatch, sleepMode, busy}, 3'h4);
		op(8'h04);
	endtask

	task automatic tPage();
		int n0;
		op(8'h06);
		n0 = starts;
		host.xfer(48, {8'h02, 24'h000200, 8'ha1, 8'hb2, 16'h0}, 0);
		chk("pg start", {starts - n0, cmdKind, cmdAddr}, {32'h1, 3'h1, 24'h000200});
		chk("head", {pgmValid, pgmData}, {1'b1, 8'ha1});
		pulse(pgmReady);
		chk("next", {pgmValid, pgmData}, {1'b1, 8'hb2});
		pulse(pgmReady);
		chk("empty", pgmValid, 0);
		pulse(engineDone);
		op(8'h06);
		n0 = starts;
		host.xfer(104, {8'h02, 24'h000300, 32'h11223344}, 0);
		repeat (2) @(posedge clk);
		chk("overrun", {starts - n0, pgmValid}, 0);
		op(8'h04);
	endtask

	//--------------------------------------------------------------
	// Main sequence and watchdog
	//--------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		engineDone = 1'b0;
		pgmReady = 1'b0;
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		tLatch();
		tErase();
		tStatusWr(8'hff);
		tStatusWr(8'h00);
		tRead();
		tIds();
		tSleep();
		tPage();
		giveVerdict();
	end

	// Planned traffic needs about 70 us; limit stays well inside the cycle budget
	initial begin
		#200000;
		errTotal++;
		giveVerdict();
	end
endmodule
